/* design/smrc_top.sv */
`default_nettype none
// Behaviour
// - Three-bit source field picks wake: none, reserved, three port-3 pins, pin, NORs.
// - Level bit sets wake polarity by XOR with the source; resets low.
// - Read-only flag is 0 after power-on, set to 1 by stop recovery.
// - Delay enable resets to on; software keeps it on with crystal clocks.
// - Bits 6..0 write-only, bit 7 read-only; lower bits read as zero.
// - In sync mode the carrier timer's first pulse aligns to demod signal.
// - With delay on, recovery runs the 2.5 ms delay; otherwise it is bypassed.
// - Recovery restarts execution at address 000Ch.
module smrc_top #(
    parameter int DELAY_CYCLES = smrc_pkg::DELAY_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [9:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        STOP_REQ,
    input  wire logic [7:0]  WAKE_PORT2,
    input  wire logic [2:0]  WAKE_PORT3,
    input  wire logic        DEMOD_EDGE,
    input  wire logic        CARRIER_REQ,
    output logic             CARRIER_START,
    output logic             CLK_STOPPED,
    output logic             CPU_RESTART,
    output logic      [15:0] RESTART_VECTOR
);
    logic [10:0] p_s1_ff, p_s2_ff, p_s3_ff, p_ok_ff;
    logic [2:0]  sel_ff;
    logic        level_ff, delay_en_ff, flag_ff, sync_en_ff, pend_ff;
    logic [31:0] cnt_ff;
    smrc_pkg::smrc_state_t state_ff, nxt_state;
    logic        wake, hit, wr_src, wr_sync, wr_cpu;
    logic [7:0]  idx;

    function automatic logic pick(input logic [2:0] s, input logic [10:0] p);
        case (s)
            smrc_pkg::SEL_PIN_A:   pick = p[8];
            smrc_pkg::SEL_PIN_B:   pick = p[9];
            smrc_pkg::SEL_PIN_C:   pick = p[10];
            smrc_pkg::SEL_PIN_D:   pick = p[7];
            smrc_pkg::SEL_NOR_LOW: pick = ~|p[3:0];
            smrc_pkg::SEL_NOR_ALL: pick = ~|p[7:0];
            default:               pick = 1'b0;
        endcase
    endfunction : pick

    // Pins are asynchronous: three stages, accept a change when stages 2 and 3 agree
    always_ff @(posedge CLK) begin
        p_s1_ff <= {WAKE_PORT3, WAKE_PORT2};
        p_s2_ff <= p_s1_ff;
        p_s3_ff <= p_s2_ff;
        for (int i = 0; i < 11; i++) begin
            if (p_s2_ff[i] == p_s3_ff[i]) begin
                p_ok_ff[i] <= p_s3_ff[i];
            end
        end
    end

    // XOR output low means the source sits at its chosen level; 000/001 have no pin
    assign wake = (sel_ff != smrc_pkg::SEL_POR_ONLY) && (sel_ff != smrc_pkg::SEL_RSVD)
                  && !(pick(sel_ff, p_ok_ff) ^ level_ff);

    assign idx    = WB_ADR_I[9:2];
    assign hit    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_src = hit && WB_WE_I && WB_SEL_I[0] && idx == smrc_pkg::SRC_IDX;
    assign wr_sync = hit && WB_WE_I && WB_SEL_I[0] && idx == smrc_pkg::SYNC_IDX;
    assign wr_cpu = hit && WB_WE_I && WB_SEL_I[0] && idx == smrc_pkg::CPU_CTRL_IDX;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= hit;
            WB_DAT_O <= 32'h0000_0000;
            if (hit && !WB_WE_I) begin
                case (idx)
                    smrc_pkg::SRC_IDX:    WB_DAT_O[7] <= flag_ff;
                    smrc_pkg::SYNC_IDX:   WB_DAT_O[0] <= sync_en_ff;
                    smrc_pkg::STATUS_IDX: WB_DAT_O[1:0] <= state_ff;
                    default:              WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bit 1 is reserved; software writes it as zero, so it is not stored
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sel_ff      <= smrc_pkg::SEL_RST;
            level_ff    <= smrc_pkg::LEVEL_RST;
            delay_en_ff <= smrc_pkg::DELAY_RST;
        end else if (wr_src) begin
            sel_ff      <= WB_DAT_I[smrc_pkg::SRC_SEL_LSB +: 3];
            delay_en_ff <= WB_DAT_I[smrc_pkg::SRC_DELAY_BIT];
            level_ff    <= WB_DAT_I[smrc_pkg::SRC_LEVEL_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sync_en_ff <= 1'b0;
        end else if (wr_sync) begin
            sync_en_ff <= WB_DAT_I[0];
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            smrc_pkg::SMRC_RUN:  if (STOP_REQ || wr_cpu) nxt_state = smrc_pkg::SMRC_STOP;
            smrc_pkg::SMRC_STOP: if (wake) nxt_state = delay_en_ff ? smrc_pkg::SMRC_WAIT
                                                                 : smrc_pkg::SMRC_RUN;
            smrc_pkg::SMRC_WAIT: if (cnt_ff == 32'(DELAY_CYCLES - 1))
                                     nxt_state = smrc_pkg::SMRC_RUN;
            default:             nxt_state = smrc_pkg::SMRC_RUN;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_ff <= smrc_pkg::SMRC_RUN;
            cnt_ff   <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff == smrc_pkg::SMRC_WAIT) ? cnt_ff + 32'h0000_0001
                                                          : 32'h0000_0000;
        end
    end

    // Flag survives the recovery itself; only the power-on reset clears it
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            flag_ff <= 1'b0;
        end else if (state_ff != smrc_pkg::SMRC_RUN && nxt_state == smrc_pkg::SMRC_RUN) begin
            flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            CLK_STOPPED    <= 1'b0;
            CPU_RESTART    <= 1'b0;
            RESTART_VECTOR <= smrc_pkg::RESTART_ADDR;
        end else begin
            CLK_STOPPED    <= nxt_state != smrc_pkg::SMRC_RUN;
            CPU_RESTART    <= state_ff != smrc_pkg::SMRC_RUN
                              && nxt_state == smrc_pkg::SMRC_RUN;
            RESTART_VECTOR <= smrc_pkg::RESTART_ADDR;
        end
    end

    // A carrier request in sync mode waits for the demod edge so the first pulse is whole
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pend_ff       <= 1'b0;
            CARRIER_START <= 1'b0;
        end else begin
            CARRIER_START <= sync_en_ff ? ((pend_ff || CARRIER_REQ) && DEMOD_EDGE)
                                        : CARRIER_REQ;
            if (sync_en_ff && CARRIER_REQ && !DEMOD_EDGE) begin
                pend_ff <= 1'b1;
            end else if (DEMOD_EDGE || !sync_en_ff) begin
                pend_ff <= 1'b0;
            end
        end
    end

    a_wake_bypass: assert property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_STOP && wake && !delay_en_ff
        |=> state_ff == smrc_pkg::SMRC_RUN && CPU_RESTART)
        else $error("bypass wake did not restart");
    a_wake_delay: assert property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_STOP && wake && delay_en_ff
        |=> state_ff == smrc_pkg::SMRC_WAIT)
        else $error("delayed wake skipped timer");
    a_por_nowake: assert property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_STOP && sel_ff == smrc_pkg::SEL_POR_ONLY
        |=> state_ff == smrc_pkg::SMRC_STOP)
        else $error("woke with power-on-only source");
    a_flag_set: assert property (@(posedge CLK) disable iff (!RESETN)
        CPU_RESTART |-> flag_ff)
        else $error("start flag not set after recovery");
    a_flag_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
        flag_ff |=> flag_ff)
        else $error("start flag cleared without reset");
    a_lower_read: assert property (@(posedge CLK) disable iff (!RESETN)
        hit && !WB_WE_I && idx == smrc_pkg::SRC_IDX
        |=> WB_ACK_O && WB_DAT_O[6:0] == 7'h00 && WB_DAT_O[7] == $past(flag_ff))
        else $error("write-only bits visible on read");
    a_delay_reset: assert property (@(posedge CLK)
        !RESETN |=> delay_en_ff && !level_ff)
        else $error("reset values wrong");
    a_level_pol: assert property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_STOP && sel_ff == smrc_pkg::SEL_PIN_A
        && (p_ok_ff[8] == level_ff) |=> state_ff != smrc_pkg::SMRC_STOP)
        else $error("active level ignored");
    a_sync_align: assert property (@(posedge CLK) disable iff (!RESETN)
        sync_en_ff && CARRIER_REQ && !DEMOD_EDGE |=> !CARRIER_START)
        else $error("carrier started before demod edge");
    a_vector: assert property (@(posedge CLK) disable iff (!RESETN)
        CPU_RESTART |-> RESTART_VECTOR == smrc_pkg::RESTART_ADDR)
        else $error("restart vector wrong");

    c_stop_wake: cover property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_STOP ##1 state_ff == smrc_pkg::SMRC_RUN);
    c_delay_done: cover property (@(posedge CLK) disable iff (!RESETN)
        state_ff == smrc_pkg::SMRC_WAIT ##1 state_ff == smrc_pkg::SMRC_RUN);
    c_sync_start: cover property (@(posedge CLK) disable iff (!RESETN)
        sync_en_ff && CARRIER_START);
endmodule : smrc_top
`default_nettype wire

/* design/smrc_pkg.sv */
`default_nettype none
package smrc_pkg;
    // Offsets are word indices, not byte addresses: byte address = 4 * index
    localparam logic [7:0] SRC_IDX       = 8'h0B;
    localparam logic [7:0] SYNC_IDX      = 8'h10;
    localparam logic [7:0] STATUS_IDX    = 8'h11;
    localparam logic [7:0] CPU_CTRL_IDX  = 8'h12;
    // Field positions of stop_recovery_control
    localparam int         SRC_SEL_LSB   = 2;
    localparam int         SRC_DELAY_BIT = 5;
    localparam int         SRC_LEVEL_BIT = 6;
    localparam int         SRC_FLAG_BIT  = 7;
    // Reset values
    localparam logic [2:0] SEL_RST       = 3'h0;
    localparam logic       LEVEL_RST     = 1'b0;
    localparam logic       DELAY_RST     = 1'b1;
    localparam logic [1:0] LOW_RST       = 2'h0;
    // Source encodings
    localparam logic [2:0] SEL_POR_ONLY  = 3'h0;
    localparam logic [2:0] SEL_RSVD      = 3'h1;
    localparam logic [2:0] SEL_PIN_A     = 3'h2;
    localparam logic [2:0] SEL_PIN_B     = 3'h3;
    localparam logic [2:0] SEL_PIN_C     = 3'h4;
    localparam logic [2:0] SEL_PIN_D     = 3'h5;
    localparam logic [2:0] SEL_NOR_LOW   = 3'h6;
    localparam logic [2:0] SEL_NOR_ALL   = 3'h7;
    // Restart vector
    localparam logic [15:0] RESTART_ADDR = 16'h000C;
    // Delay timer: least time 2.5 ms = 2500000 ns, rounded up
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         DELAY_NS      = 2500000;
    localparam int         DELAY_CYC     = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        SMRC_RUN  = 2'h0,
        SMRC_STOP = 2'h1,
        SMRC_WAIT = 2'h3
    } smrc_state_t;
endpackage : smrc_pkg
`default_nettype wire

/* test/smrc_wake_model.sv */
`default_nettype none
module smrc_wake_model (
    input  wire logic       clk,
    input  wire logic [7:0] p2_cmd,
    input  wire logic [2:0] p3_cmd,
    output logic      [7:0] wake_port2,
    output logic      [2:0] wake_port3
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move one edge after the command, so the bench never races the pins
    always_ff @(posedge clk) begin
        wake_port2 <= p2_cmd;
        wake_port3 <= p3_cmd;
    end
endmodule : smrc_wake_model
`default_nettype wire

/* test/smrc_top_bench.sv */
`default_nettype none
module smrc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 20;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        stop_req = 1'b0, demod = 1'b0, creq = 1'b0;
    logic        ack, cstart, stopped, restart;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dati = 32'h0, dato, q;
    logic [15:0] vec;
    logic [7:0]  p2 = 8'h00, wp2;
    logic [2:0]  p3 = 3'h0, wp3;
    int          n_errors = 0, total_checks = 0, n, starts = 0;
    // Source byte, idle and active pin levels for every waking code
    logic [7:0]  src_t [6] = '{8'h08, 8'h4C, 8'h10, 8'h74, 8'h18, 8'h5C};
    logic [7:0]  idl2 [6]  = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'hF0, 8'h01};
    logic [7:0]  act2 [6]  = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h00};
    logic [2:0]  idl3 [6]  = '{3'h1, 3'h5, 3'h4, 3'h0, 3'h0, 3'h0};
    logic [2:0]  act3 [6]  = '{3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0};
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (cstart === 1'b1) starts++;
    end
    smrc_top #(.DELAY_CYCLES(DLY)) smrc_top_inst (
        .CLK(clk), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato),
        .WB_ACK_O(ack), .STOP_REQ(stop_req), .WAKE_PORT2(wp2), .WAKE_PORT3(wp3),
        .DEMOD_EDGE(demod), .CARRIER_REQ(creq), .CARRIER_START(cstart),
        .CLK_STOPPED(stopped), .CPU_RESTART(restart), .RESTART_VECTOR(vec));
    smrc_wake_model smrc_wake_model_inst (
        .clk(clk), .p2_cmd(p2), .p3_cmd(p3), .wake_port2(wp2), .wake_port3(wp3));
    task automatic summarize;
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {idx, 2'b00};
        dati <= {24'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        chk("ack", 32'h1, {31'h0, ack});
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wait_restart(input int lo, input int hi);
        n = 0;
        while (restart !== 1'b1 && n < hi + 5) begin
            @(posedge clk);
            n++;
        end
        chk("restart latency", 32'h1, {31'h0, n >= lo && n <= hi});
    endtask : wait_restart
    // Codes that never wake leave the block stopped; only reset gets it out
    task automatic stuck(input logic [7:0] s);
        bus(1'b1, 8'h0B, s);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        p2 <= 8'hFF;
        p3 <= 3'h7;
        repeat (20) @(posedge clk);
        p2 <= 8'h00;
        p3 <= 3'h0;
        repeat (20) @(posedge clk);
        chk("no wake", 32'h1, {31'h0, stopped});
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("run after reset", 32'h0, {31'h0, stopped});
        bus(1'b0, 8'h0B, 8'h00);
        chk("flag cleared", 32'h0, q);
    endtask : stuck
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("vector", 32'h000C, {16'h0, vec});
        bus(1'b0, 8'h0B, 8'h00);
        chk("reset read", 32'h0, q);
        bus(1'b0, 8'h3F, 8'h00);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 6; i++) begin
            p2 <= idl2[i];
            p3 <= idl3[i];
            repeat (6) @(posedge clk);
            bus(1'b1, 8'h0B, src_t[i]);
            bus(1'b1, 8'h12, 8'h01);
            repeat (10) @(posedge clk);
            chk("held stop", 32'h1, {31'h0, stopped});
            bus(1'b0, 8'h11, 8'h00);
            chk("state stop", 32'h1, q);
            p2 <= act2[i];
            p3 <= act3[i];
            if (i == 3) wait_restart(DLY, DLY + 14);
            else wait_restart(1, 12);
            chk("running", 32'h0, {31'h0, stopped});
            bus(1'b0, 8'h0B, 8'h00);
            chk("flag", 32'h80, q);
        end
        bus(1'b1, 8'h10, 8'h01);
        creq <= 1'b1;
        @(posedge clk);
        creq <= 1'b0;
        repeat (4) @(posedge clk);
        chk("held carrier", 32'h0, starts);
        demod <= 1'b1;
        @(posedge clk);
        demod <= 1'b0;
        repeat (3) @(posedge clk);
        chk("aligned carrier", 32'h1, starts);
        bus(1'b1, 8'h10, 8'h00);
        creq <= 1'b1;
        @(posedge clk);
        creq <= 1'b0;
        repeat (3) @(posedge clk);
        chk("free carrier", 32'h2, starts);
        stuck(8'h04);
        stuck(8'h00);
        summarize();
    end
endmodule : smrc_top_bench
`default_nettype wire
